/* rtl/asr_consts.svh */
`ifndef ASR_CONSTS_SVH
`define ASR_CONSTS_SVH

// register indices as printed; byte address is four times the index
`define ASR_IDX_CTRL 4'h1
`define ASR_IDX_MON 4'h2
`define ASR_IDX_STAT 4'h3

// reset values
`define ASR_RST_CTRL 8'h74
`define ASR_RST_MON 8'h60
`define ASR_RST_STAT 8'h00

// control register fields
`define ASR_CTRL_HV_EN 6
`define ASR_CTRL_CONV2_EN 5
`define ASR_CTRL_CLK_EN 4
`define ASR_CTRL_TX_EN 3
`define ASR_CTRL_TRIM_HI 2
`define ASR_CTRL_TRIM_LO 0

// monitor configuration fields
`define ASR_MON_HV_MASK 6
`define ASR_MON_S2_MASK 5
`define ASR_MON_FILT_MASK 4
`define ASR_MON_SEL_HI 3
`define ASR_MON_SEL_LO 1

// writable bits per register, reserved bits excluded
`define ASR_CTRL_WMASK 8'h7f
`define ASR_MON_WMASK 8'h7e

`endif

/* rtl/asr_pkg.sv */
package asr_pkg;

    // analog output source selection
    typedef enum logic [2:0] {
        ASR_AOUT_OFF = 3'h0,
        ASR_AOUT_BUS_IN = 3'h1,
        ASR_AOUT_FILTER = 3'h2,
        ASR_AOUT_HV_RAIL = 3'h3,
        ASR_AOUT_SUPPLY2 = 3'h4,
        ASR_AOUT_ANALOG_SUPPLY = 3'h5,
        ASR_AOUT_BUS_CURRENT = 3'h6,
        ASR_AOUT_TEMPERATURE = 3'h7
    } asr_aout_sel_t;

    // live monitor and thermal inputs
    typedef struct packed {
        logic hv_rail_ok;
        logic second_supply_ok;
        logic bus_voltage_ok;
        logic filter_voltage_ok;
        logic xtal_running;
        logic thermal_warning;
        logic thermal_shutdown_seen;
    } asr_monitor_t;

    // control outputs towards the analog blocks
    typedef struct packed {
        logic hv_regulator_enable;
        logic second_converter_enable;
        logic clock_output_enable;
        logic tx_activity_pin_enable;
        logic [2:0] hv_regulator_current_trim;
        logic hv_monitor_mask;
        logic second_supply_monitor_mask;
        logic filter_monitor_mask;
        asr_aout_sel_t analog_out_select;
    } asr_control_t;

endpackage : asr_pkg

/* rtl/asr_regs.sv */
`timescale 1ns/1ps
`include "asr_consts.svh"

module asr_regs
    import asr_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // live monitor inputs
    input wire asr_monitor_t monitor_in,
    input wire logic tx_activity,
    input wire logic ext_clock_src,
    // control towards the analog blocks
    output asr_control_t control_out,
    // pins
    output logic ext_clock_out,
    output logic tx_activity_pin_o,
    output logic tx_activity_pin_oe,
    output logic save_request_n
);

    // decode a word address into a register index, zero when above 0x3f or not word aligned
    function automatic logic [3:0] reg_index(input logic [31:0] addr);
        if (addr[31:6] != 26'h0 || addr[1:0] != 2'b00) begin
            reg_index = 4'h0;
        end else begin
            reg_index = addr[5:2];
        end
    endfunction : reg_index

    logic [7:0] analog_control_primary;
    logic [7:0] monitor_configuration;
    logic [7:0] analog_status;
    logic wr_pending;
    logic [3:0] wr_index;
    logic [31:0] next_hrdata;
    logic [7:0] next_status;
    logic access;

    // zero wait states, always okay
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign access = hsel && hready && htrans[1];

    // capture the address phase of a write for the following data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pending <= 1'b0;
            wr_index <= 4'h0;
        end else if (hready) begin
            wr_pending <= access && hwrite;
            wr_index <= reg_index(haddr);
        end
    end

    // control register; reserved bit 7 is never stored
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            analog_control_primary <= `ASR_RST_CTRL;
        end else if (wr_pending && wr_index == `ASR_IDX_CTRL) begin
            analog_control_primary <= hwdata[7:0] & `ASR_CTRL_WMASK;
        end
    end

    // monitor configuration; bits 7 and 0 reserved
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            monitor_configuration <= `ASR_RST_MON;
        end else if (wr_pending && wr_index == `ASR_IDX_MON) begin
            monitor_configuration <= hwdata[7:0] & `ASR_MON_WMASK;
        end
    end

    // live status image, registered once so reads are glitch free
    always_comb begin
        next_status = 8'h00;
        next_status[6] = monitor_in.hv_rail_ok;
        next_status[5] = monitor_in.second_supply_ok;
        next_status[4] = monitor_in.bus_voltage_ok;
        next_status[3] = monitor_in.filter_voltage_ok;
        next_status[2] = monitor_in.xtal_running;
        next_status[1] = monitor_in.thermal_warning;
        next_status[0] = monitor_in.thermal_shutdown_seen;
    end

    // status has no write path at all, so bus writes to it fall away
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            analog_status <= `ASR_RST_STAT;
        end else begin
            analog_status <= next_status;
        end
    end

    // read mux; unmapped addresses read zero
    // a read right behind a write to the same register sees the new value, since
    // the store only lands at the end of the write's data phase
    always_comb begin
        next_hrdata = 32'h0000_0000;
        case (reg_index(haddr))
            `ASR_IDX_CTRL: begin
                if (wr_pending && wr_index == `ASR_IDX_CTRL) begin
                    next_hrdata = {24'h00_0000, hwdata[7:0] & `ASR_CTRL_WMASK};
                end else begin
                    next_hrdata = {24'h00_0000, analog_control_primary};
                end
            end
            `ASR_IDX_MON: begin
                if (wr_pending && wr_index == `ASR_IDX_MON) begin
                    next_hrdata = {24'h00_0000, hwdata[7:0] & `ASR_MON_WMASK};
                end else begin
                    next_hrdata = {24'h00_0000, monitor_configuration};
                end
            end
            `ASR_IDX_STAT: next_hrdata = {24'h00_0000, analog_status};
            default: next_hrdata = 32'h0000_0000;
        endcase
    end

    // read data is registered and stands in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (access && !hwrite) begin
            hrdata <= next_hrdata;
        end
    end

    // field breakout towards the analog blocks
    always_comb begin
        control_out.hv_regulator_enable = analog_control_primary[`ASR_CTRL_HV_EN];
        control_out.second_converter_enable = analog_control_primary[`ASR_CTRL_CONV2_EN];
        control_out.clock_output_enable = analog_control_primary[`ASR_CTRL_CLK_EN];
        control_out.tx_activity_pin_enable = analog_control_primary[`ASR_CTRL_TX_EN];
        control_out.hv_regulator_current_trim =
            analog_control_primary[`ASR_CTRL_TRIM_HI:`ASR_CTRL_TRIM_LO];
        control_out.hv_monitor_mask = monitor_configuration[`ASR_MON_HV_MASK];
        control_out.second_supply_monitor_mask = monitor_configuration[`ASR_MON_S2_MASK];
        control_out.filter_monitor_mask = monitor_configuration[`ASR_MON_FILT_MASK];
        control_out.analog_out_select =
            asr_aout_sel_t'(monitor_configuration[`ASR_MON_SEL_HI:`ASR_MON_SEL_LO]);
    end

    // clock gate is combinational so the clock shape passes through
    assign ext_clock_out = ext_clock_src & analog_control_primary[`ASR_CTRL_CLK_EN];

    // pin released (oe low) when disabled, so the board sees tri-state
    assign tx_activity_pin_oe = analog_control_primary[`ASR_CTRL_TX_EN];
    assign tx_activity_pin_o = tx_activity & analog_control_primary[`ASR_CTRL_TX_EN];

    // save request: low when any included monitor is not ok; bus voltage always counts
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            save_request_n <= 1'b1;
        end else begin
            save_request_n <= monitor_in.bus_voltage_ok
                && (monitor_configuration[`ASR_MON_HV_MASK] || monitor_in.hv_rail_ok)
                && (monitor_configuration[`ASR_MON_S2_MASK] || monitor_in.second_supply_ok)
                && (monitor_configuration[`ASR_MON_FILT_MASK] || monitor_in.filter_voltage_ok);
        end
    end

endmodule : asr_regs

/* sim/asr_regs_sva.sv */
`timescale 1ns/1ps
`include "asr_consts.svh"
module asr_regs_sva
    import asr_pkg::*;
(
    // clock, reset and bus
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    // monitors and controls
    input wire asr_monitor_t monitor_in,
    input wire logic tx_activity,
    input wire logic ext_clock_src,
    input wire asr_control_t control_out,
    // pins
    input wire logic ext_clock_out,
    input wire logic tx_activity_pin_o,
    input wire logic tx_activity_pin_oe,
    input wire logic save_request_n
);
    // transfers taken at this edge, decoded per register
    wire logic take = hsel & hready & htrans[1];
    wire logic rd = take & !hwrite;
    wire logic wr_ctrl = take & hwrite & (haddr == {26'h0, `ASR_IDX_CTRL, 2'h0});
    wire logic wr_mon = take & hwrite & (haddr == {26'h0, `ASR_IDX_MON, 2'h0});
    wire logic rd_stat = rd & (haddr == {26'h0, `ASR_IDX_STAT, 2'h0});
    // supplies healthy: bus always counts, the others only when unmasked
    wire logic save_ok = monitor_in.bus_voltage_ok & (control_out.hv_monitor_mask | monitor_in.hv_rail_ok)
        & (control_out.second_supply_monitor_mask | monitor_in.second_supply_ok)
        & (control_out.filter_monitor_mask | monitor_in.filter_voltage_ok);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    reset_val_a: assert property ($rose(hresetn) |-> control_out == 13'h1d30)
        else $error("control outputs differ from reset values");
    ctrl_wr_a: assert property (wr_ctrl |=> ##1 control_out[12:6] == $past(hwdata[6:0]))
        else $error("control fields did not take written data");
    mon_wr_a: assert property (wr_mon |=> ##1 control_out[5:0] == {$past(hwdata[6:4]), $past(hwdata[3:1])})
        else $error("monitor config did not take written data");
    clk_gate_a: assert property (ext_clock_out == (ext_clock_src & control_out.clock_output_enable))
        else $error("clock output gating wrong");
    tx_oe_a: assert property (tx_activity_pin_oe == control_out.tx_activity_pin_enable)
        else $error("tx pin enable wrong");
    tx_data_a: assert property (tx_activity_pin_oe |-> tx_activity_pin_o == tx_activity)
        else $error("tx pin data wrong");
    save_calc_a: assert property (1'b1 |=> save_request_n == $past(save_ok))
        else $error("save output wrong");
    stat_rd_a: assert property (rd_stat && $past(hresetn) && $stable(monitor_in) |=> hrdata[6:0] == $past(monitor_in))
        else $error("status read does not follow inputs");
    resv_rd_a: assert property (rd |=> hrdata[31:7] == 25'h0)
        else $error("reserved read bits not zero");
    cover property (wr_ctrl);
    cover property (rd_stat);
    cover property (!save_request_n);
endmodule : asr_regs_sva

bind asr_regs asr_regs_sva i_asr_regs_sva (.*);

/* sim/asr_regs_tb.sv */
`timescale 1ns/1ps
`include "asr_consts.svh"
module asr_regs_tb
    import asr_pkg::*;
;
    typedef struct {logic [31:0] a; logic [7:0] d; logic [7:0] e;} asr_row_t;
    localparam logic [31:0] a_ctrl = {26'h0, `ASR_IDX_CTRL, 2'h0};
    localparam logic [31:0] a_mon = {26'h0, `ASR_IDX_MON, 2'h0};
    localparam logic [31:0] a_stat = {26'h0, `ASR_IDX_STAT, 2'h0};
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b1;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, r;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic hreadyout, hresp, ext_clock_out, pin_o, pin_oe, save_request_n;
    logic tx_activity = 1'b0, ext_clock_src = 1'b0;
    asr_monitor_t monitor_in = '0;
    asr_control_t control_out;
    int bad_count = 0, cmp_count = 0;
    // write, then read back; status writes and holes must change nothing
    asr_row_t rows [7] = '{'{a_ctrl, 8'hff, 8'h7f}, '{a_mon, 8'hff, 8'h7e}, '{a_mon, 8'h81, 8'h00},
        '{a_stat, 8'hff, 8'h55}, '{a_ctrl, 8'h08, 8'h08}, '{32'h0000_0010, 8'hff, 8'h00}, '{32'h0000_0005, 8'hff, 8'h00}};
    asr_regs i_asr_regs (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .monitor_in(monitor_in), .tx_activity(tx_activity), .ext_clock_src(ext_clock_src),
        .control_out(control_out), .ext_clock_out(ext_clock_out), .tx_activity_pin_o(pin_o),
        .tx_activity_pin_oe(pin_oe), .save_request_n(save_request_n));
    // 40 MHz clock
    initial forever #12.5 hclk = ~hclk;
    task automatic wrap_up();
        if (bad_count == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // single ahb transfer; waits on hready rather than assuming a latency
    task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask : xfer
    function automatic logic exp_save(asr_monitor_t m, logic [7:0] c);
        return m.bus_voltage_ok & (c[6] | m.hv_rail_ok) & (c[5] | m.second_supply_ok) & (c[4] | m.filter_voltage_ok);
    endfunction : exp_save
    // reset for five cycles, then read every register back
    task automatic reset_check();
        hresetn <= 1'b0;
        monitor_in <= '0;
        repeat (5) @(posedge hclk);
        chk({hreadyout, hresp, control_out, save_request_n, hrdata}, {1'b1, 1'b0, 13'h1d30, 1'b1, 32'h0});
        hresetn <= 1'b1;
        @(posedge hclk);
        xfer(a_ctrl, 1'b0, 32'h0, r);
        chk(r, 8'h74);
        xfer(a_mon, 1'b0, 32'h0, r);
        chk(r, 8'h60);
        xfer(a_stat, 1'b0, 32'h0, r);
        chk(r, 8'h00);
    endtask : reset_check
    // watchdog, well beyond the expected run of about 630 cycles
    initial begin
        #100000;
        bad_count++;
        wrap_up();
    end
    initial begin
        reset_check();
        monitor_in <= 7'h55;
        foreach (rows[i]) begin
            xfer(rows[i].a, 1'b1, rows[i].d, r);
            xfer(rows[i].a, 1'b0, 32'h0, r);
            chk(r, rows[i].e);
        end
        xfer(a_ctrl, 1'b0, 32'h0, r);
        chk(r, 8'h08);
        // every trim and output-select code, with enables and pin inputs varied
        for (int i = 0; i < 8; i++) begin
            ext_clock_src <= i[1];
            tx_activity <= i[1];
            xfer(a_ctrl, 1'b1, {1'b1, i[2:0], i[0], i[2:0]}, r);
            xfer(a_mon, 1'b1, {1'b1, i[2:0], i[2:0], 1'b1}, r);
            xfer(a_stat, 1'b0, 32'h0, r);
            chk(control_out, {i[2:0], i[0], i[2:0], i[2:0], i[2:0]});
            chk({ext_clock_out, pin_oe, pin_o}, {i[0] & i[1], i[0], i[0] & i[1]});
        end
        // every mask setting against every supply pattern; status follows live inputs
        for (int k = 0; k < 8; k++) begin
            xfer(a_mon, 1'b1, {1'b0, k[2:0], 4'h0}, r);
            for (int v = 0; v < 16; v++) begin
                monitor_in <= {v[3:0], k[2:0]};
                repeat (2) @(posedge hclk);
                chk(save_request_n, exp_save({v[3:0], k[2:0]}, {1'b0, k[2:0], 4'h0}));
                xfer(a_stat, 1'b0, 32'h0, r);
                chk(r, {v[3:0], k[2:0]});
            end
        end
        reset_check();
        wrap_up();
    end
endmodule : asr_regs_tb
